// ---- common/rcsap_consts.svh ----
// Offsets, field positions, reset values and timing counts of the aux pin and checksum slice
`ifndef RCSAP_CONSTS_SVH
`define RCSAP_CONSTS_SVH

// ****************************************
// Register indexes (byte address = 4 x index)
// ****************************************
`define RCSAP_IDX_PAD_A2 8'hA2
`define RCSAP_IDX_PAD_A3 8'hA3
`define RCSAP_IDX_SEC2_SUM 8'hBE
`define RCSAP_IDX_SEC3_TSB 8'hC0
`define RCSAP_IDX_AUX_CFG 8'hC1
`define RCSAP_IDX_SEC3_REF 8'hF0
`define RCSAP_IDX_STATUS 8'hF1
`define RCSAP_IDX_SEC3_CALC 8'hF2

// ****************************************
// Writable masks, fixed bits, reset values
// ****************************************
`define RCSAP_MASK_PAD_A2 16'hFF00
`define RCSAP_FIXED_PAD_A2 16'h0000
`define RCSAP_RST_PAD_A2 16'h0000
`define RCSAP_MASK_FULL 16'hFFFF
`define RCSAP_RST_ZERO 16'h0000
`define RCSAP_MASK_SEC3_TSB 16'h8007
`define RCSAP_FIXED_SEC3_TSB 16'h0000
`define RCSAP_RST_SEC3_TSB 16'h0000
`define RCSAP_MASK_AUX_CFG 16'h7FFF
`define RCSAP_FIXED_AUX_CFG 16'h8000
`define RCSAP_RST_AUX_CFG 16'h8000

// ****************************************
// Field positions
// ****************************************
`define RCSAP_SEC3_EN_BIT 15
`define RCSAP_TSB_LSB 0
`define RCSAP_FMT_LSB 10
`define RCSAP_DIR_LSB 8
`define RCSAP_TB_LSB 4
`define RCSAP_OUT_LSB 0
`define RCSAP_STAT_FAULT_BIT 0
`define RCSAP_STAT_LEVEL_LSB 1

// ****************************************
// Decode time bases in main-clock periods
// ****************************************
`define RCSAP_TB0_CYCLES 10'd16
`define RCSAP_TB1_CYCLES 10'd64
`define RCSAP_TB2_CYCLES 10'd256
`define RCSAP_TB3_CYCLES 11'd1024
`define RCSAP_PWM_CNT_MAX 8'hFF

// ****************************************
// Checksum polynomial and seed
// ****************************************
`define RCSAP_CRC_POLY 16'h1021
`define RCSAP_CRC_SEED 16'hFFFF

`endif

// ---- common/rcsap_pkg.sv ----
// Types shared by the aux pin and checksum slice
package rcsap_pkg;
   typedef logic [15:0] rcsap_word_t;
   typedef logic signed [6:0] rcsap_units_t;
   typedef enum logic [1:0] {
      RCSAP_TB_16,
      RCSAP_TB_64,
      RCSAP_TB_256,
      RCSAP_TB_1024
   } rcsap_timebase_t;
endpackage

// ---- verilog/rcsap_pwm_decode.sv ----
// Pulse-width decoder that turns a modulated aux pin input into a logic level
`include "rcsap_consts.svh"

module rcsap_pwm_decode
   import rcsap_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Control
   input wire logic i_enable,
   input wire rcsap_timebase_t i_timebase,
   // Synchronised pin level
   input wire logic i_level,
   // Decoded level
   output logic o_level
);

   logic [10:0] prescale;
   logic [10:0] limit;
   logic tick;
   logic level_q;
   logic [7:0] high_cnt;
   logic [7:0] low_cnt;

   // ****************************************
   // Time-base divider
   // ****************************************
   always_comb
   begin
      unique case (i_timebase)
         RCSAP_TB_16: limit = {1'b0, `RCSAP_TB0_CYCLES};
         RCSAP_TB_64: limit = {1'b0, `RCSAP_TB1_CYCLES};
         RCSAP_TB_256: limit = {1'b0, `RCSAP_TB2_CYCLES};
         RCSAP_TB_1024: limit = `RCSAP_TB3_CYCLES;
      endcase
   end

   assign tick = i_enable && (prescale == limit - 11'd1);

   always_ff @(posedge i_clk)
   begin
      if (i_srst || !i_enable || tick)
         prescale <= '0;
      else
         prescale <= prescale + 11'd1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         level_q <= 1'b0;
      else
         level_q <= i_level;
   end

   // ****************************************
   // High and low time measurement
   // ****************************************
   // Counts saturate, so a stuck pin still resolves to a level
   always_ff @(posedge i_clk)
   begin
      if (i_srst || !i_enable || (i_level && !level_q))
      begin
         high_cnt <= '0;
         low_cnt <= '0;
      end
      else if (tick)
      begin
         if (i_level && high_cnt != `RCSAP_PWM_CNT_MAX)
            high_cnt <= high_cnt + 8'd1;
         if (!i_level && low_cnt != `RCSAP_PWM_CNT_MAX)
            low_cnt <= low_cnt + 8'd1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_level <= 1'b0;
      else if (!i_enable)
         o_level <= i_level;
      else if (i_level && !level_q)
         o_level <= (high_cnt > low_cnt);
      else if (high_cnt == `RCSAP_PWM_CNT_MAX)
         o_level <= 1'b1;
      else if (low_cnt == `RCSAP_PWM_CNT_MAX)
         o_level <= 1'b0;
   end

endmodule

// ---- verilog/rcsap_regs.sv ----
// Register slice: checksum pads and words, section 3 check, test source B, aux pin pair
//
// How it works
// - Pad bits read and write, do nothing, except A2 bits 7:0, which read zero
// - Reserved bits ignore writes, read fixed
// - Section 2 reference word at BEh
// - C0h bit 15 enables section 3 check
// - C0h bits 2:0 set source B level
// - Level codes decode to signed unit multiples
// - Direction bits choose input or output
// - Format bit selects pulse-width decoded input
// - Outputs always static, never modulated
// - Aux configuration resets to 8000h
// - Out level drives only when output
// - Time-base field picks decode time unit
`include "rcsap_consts.svh"

module rcsap_regs
   import rcsap_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Avalon-MM slave
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Aux pins
   input wire logic [1:0] i_aux_pin,
   output logic [1:0] o_aux_pin_out,
   output logic [1:0] o_aux_pin_oe,
   // Device-side view
   output logic [1:0] o_aux_level,
   output logic [2:0] o_test_source_b_level,
   output rcsap_units_t o_test_source_b_units,
   output logic o_section3_check_enable,
   output logic o_section3_fault
);

   rcsap_word_t crc_check_pad_a2;
   rcsap_word_t crc_check_pad_a3;
   rcsap_word_t section2_checksum_word;
   rcsap_word_t section3_check_test_source_cfg;
   rcsap_word_t aux_pin_pair_cfg;
   rcsap_word_t section3_checksum_ref;
   rcsap_word_t section3_checksum_calc;
   rcsap_word_t next_crc;
   rcsap_word_t wr_mask;
   rcsap_word_t wr_merged_a2;
   rcsap_word_t wr_merged_a3;
   rcsap_word_t wr_merged_be;
   rcsap_word_t wr_merged_c0;
   rcsap_word_t wr_merged_c1;
   rcsap_word_t wr_merged_ref;
   rcsap_word_t rd_word;
   logic [7:0] index;
   logic request;
   logic ack;
   logic wr_fire;
   logic rd_capture;
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic [1:0] pwm_level;
   logic [1:0] aux_fmt;
   logic [1:0] aux_dir;
   logic [1:0] aux_out;
   logic [1:0] next_aux_level;

   // ****************************************
   // Bus handshake
   // ****************************************
   // One wait cycle gives a registered read path at no extra cost
   assign index = i_avs_address[9:2];
   assign request = i_avs_read || i_avs_write;
   assign o_avs_waitrequest = request && !ack;
   assign wr_fire = i_avs_write && ack;
   assign rd_capture = i_avs_read && !ack;
   assign wr_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         ack <= 1'b0;
      else
         ack <= request && !ack;
   end

   // ****************************************
   // Write merge per byte lane
   // ****************************************
   // Upper lanes carry nothing, the registers are 16 bits
   always_comb
   begin
      wr_merged_a2 = (crc_check_pad_a2 & ~wr_mask) | (i_avs_writedata[15:0] & wr_mask);
      wr_merged_a3 = (crc_check_pad_a3 & ~wr_mask) | (i_avs_writedata[15:0] & wr_mask);
      wr_merged_be = (section2_checksum_word & ~wr_mask) | (i_avs_writedata[15:0] & wr_mask);
      wr_merged_c0 = (section3_check_test_source_cfg & ~wr_mask) | (i_avs_writedata[15:0] & wr_mask);
      wr_merged_c1 = (aux_pin_pair_cfg & ~wr_mask) | (i_avs_writedata[15:0] & wr_mask);
      wr_merged_ref = (section3_checksum_ref & ~wr_mask) | (i_avs_writedata[15:0] & wr_mask);
   end

   // ****************************************
   // Checksum pad registers
   // ****************************************
   // Pads stored, A2 low byte held zero
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         crc_check_pad_a2 <= `RCSAP_RST_PAD_A2;
      else if (wr_fire && index == `RCSAP_IDX_PAD_A2)
         crc_check_pad_a2 <= (wr_merged_a2 & `RCSAP_MASK_PAD_A2) | `RCSAP_FIXED_PAD_A2;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         crc_check_pad_a3 <= `RCSAP_RST_ZERO;
      else if (wr_fire && index == `RCSAP_IDX_PAD_A3)
         crc_check_pad_a3 <= wr_merged_a3 & `RCSAP_MASK_FULL;
   end

   // ****************************************
   // Checksum reference words
   // ****************************************
   // Section 2 reference
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         section2_checksum_word <= `RCSAP_RST_ZERO;
      else if (wr_fire && index == `RCSAP_IDX_SEC2_SUM)
         section2_checksum_word <= wr_merged_be;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         section3_checksum_ref <= `RCSAP_RST_ZERO;
      else if (wr_fire && index == `RCSAP_IDX_SEC3_REF)
         section3_checksum_ref <= wr_merged_ref;
   end

   // ****************************************
   // Section 3 enable and test source B
   // ****************************************
   // Enable and level, rest zero
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         section3_check_test_source_cfg <= `RCSAP_RST_SEC3_TSB;
      else if (wr_fire && index == `RCSAP_IDX_SEC3_TSB)
         section3_check_test_source_cfg <= (wr_merged_c0 & `RCSAP_MASK_SEC3_TSB) | `RCSAP_FIXED_SEC3_TSB;
   end

   assign o_section3_check_enable = section3_check_test_source_cfg[`RCSAP_SEC3_EN_BIT];
   assign o_test_source_b_level = section3_check_test_source_cfg[`RCSAP_TSB_LSB +: 3];

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_test_source_b_units <= 7'sd1;
      else
      begin
         unique case (section3_check_test_source_cfg[`RCSAP_TSB_LSB +: 3])
            3'b000: o_test_source_b_units <= 7'sd1;
            3'b001: o_test_source_b_units <= 7'sd2;
            3'b010: o_test_source_b_units <= 7'sd4;
            3'b011: o_test_source_b_units <= 7'sd9;
            3'b100: o_test_source_b_units <= 7'sd18;
            3'b101: o_test_source_b_units <= 7'sd36;
            3'b110: o_test_source_b_units <= -7'sd4;
            3'b111: o_test_source_b_units <= -7'sd9;
         endcase
      end
   end

   // ****************************************
   // Aux pin configuration
   // ****************************************
   // Bit 15 stays one
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         aux_pin_pair_cfg <= `RCSAP_RST_AUX_CFG;
      else if (wr_fire && index == `RCSAP_IDX_AUX_CFG)
         aux_pin_pair_cfg <= (wr_merged_c1 & `RCSAP_MASK_AUX_CFG) | `RCSAP_FIXED_AUX_CFG;
   end

   assign aux_fmt = aux_pin_pair_cfg[`RCSAP_FMT_LSB +: 2];
   assign aux_dir = aux_pin_pair_cfg[`RCSAP_DIR_LSB +: 2];
   assign aux_out = aux_pin_pair_cfg[`RCSAP_OUT_LSB +: 2];

   // ****************************************
   // Aux pin input path
   // ****************************************
   // Pins are asynchronous, two stages before use
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= i_aux_pin;
         pin_sync <= pin_meta;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gen_pin
         rcsap_pwm_decode i_rcsap_pwm_decode
         (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_enable(aux_fmt[g] && !aux_dir[g]),
            .i_timebase(rcsap_timebase_t'(aux_pin_pair_cfg[`RCSAP_TB_LSB + 2 * g +: 2])),
            .i_level(pin_sync[g]),
            .o_level(pwm_level[g])
         );

         always_comb
         begin
            if (aux_dir[g])
               next_aux_level[g] = aux_out[g];
            else if (aux_fmt[g])
               next_aux_level[g] = pwm_level[g];
            else
               next_aux_level[g] = pin_sync[g];
         end

         always_ff @(posedge i_clk)
         begin
            if (i_srst)
            begin
               o_aux_pin_oe[g] <= 1'b0;
               o_aux_pin_out[g] <= 1'b0;
            end
            else
            begin
               o_aux_pin_oe[g] <= aux_dir[g];
               o_aux_pin_out[g] <= aux_dir[g] && aux_out[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_aux_level <= '0;
      else
         o_aux_level <= next_aux_level;
   end

   // ****************************************
   // Section 3 checksum
   // ****************************************
   // Only the section words held here take part in the sum
   function automatic rcsap_word_t crc_words(input logic [31:0] data);
      rcsap_word_t crc;
      crc = `RCSAP_CRC_SEED;
      for (int i = 31; i >= 0; i--)
      begin
         if (crc[15] ^ data[i])
            crc = (crc << 1) ^ `RCSAP_CRC_POLY;
         else
            crc = crc << 1;
      end
      return crc;
   endfunction

   assign next_crc = crc_words({section3_check_test_source_cfg, aux_pin_pair_cfg});

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         section3_checksum_calc <= `RCSAP_RST_ZERO;
      else
         section3_checksum_calc <= next_crc;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_section3_fault <= 1'b0;
      else if (o_section3_check_enable && section3_checksum_calc != section3_checksum_ref)
         o_section3_fault <= 1'b1;
      else if (wr_fire && index == `RCSAP_IDX_STATUS && i_avs_byteenable[0]
               && i_avs_writedata[`RCSAP_STAT_FAULT_BIT])
         o_section3_fault <= 1'b0;
   end

   // ****************************************
   // Read path
   // ****************************************
   // Unmapped indexes read zero and ignore writes
   always_comb
   begin
      rd_word = '0;
      unique case (index)
         `RCSAP_IDX_PAD_A2: rd_word = crc_check_pad_a2;
         `RCSAP_IDX_PAD_A3: rd_word = crc_check_pad_a3;
         `RCSAP_IDX_SEC2_SUM: rd_word = section2_checksum_word;
         `RCSAP_IDX_SEC3_TSB: rd_word = section3_check_test_source_cfg;
         `RCSAP_IDX_AUX_CFG: rd_word = aux_pin_pair_cfg;
         `RCSAP_IDX_SEC3_REF: rd_word = section3_checksum_ref;
         `RCSAP_IDX_STATUS:
         begin
            rd_word[`RCSAP_STAT_FAULT_BIT] = o_section3_fault;
            rd_word[`RCSAP_STAT_LEVEL_LSB +: 2] = o_aux_level;
         end
         `RCSAP_IDX_SEC3_CALC: rd_word = section3_checksum_calc;
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_avs_readdata <= '0;
      else if (rd_capture)
         o_avs_readdata <= {16'h0000, rd_word};
   end

endmodule

// ---- bench/rcsap_regs_checker.sv ----
// Port-level assertions for the aux pin and checksum register slice
`include "rcsap_consts.svh"

module rcsap_regs_checker
   import rcsap_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Avalon-MM slave
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Aux pins
   input wire logic [1:0] i_aux_pin,
   input wire logic [1:0] o_aux_pin_out,
   input wire logic [1:0] o_aux_pin_oe,
   // Device-side view
   input wire logic [1:0] o_aux_level,
   input wire logic [2:0] o_test_source_b_level,
   input wire rcsap_units_t o_test_source_b_units,
   input wire logic o_section3_check_enable,
   input wire logic o_section3_fault
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   function automatic rcsap_units_t units_of(input logic [2:0] c);
      logic [6:0] t [8];
      t = '{7'h01, 7'h02, 7'h04, 7'h09, 7'h12, 7'h24, 7'h7c, 7'h77};
      return rcsap_units_t'(t[c]);
   endfunction

   // ****************************************
   // Accepted full-word writes
   // ****************************************
   sequence c1_wr_s;
      i_avs_write && !o_avs_waitrequest && i_avs_address[9:2] == `RCSAP_IDX_AUX_CFG && i_avs_byteenable[1:0] == 2'b11;
   endsequence
   sequence c0_wr_s;
      i_avs_write && !o_avs_waitrequest && i_avs_address[9:2] == `RCSAP_IDX_SEC3_TSB && i_avs_byteenable[1:0] == 2'b11;
   endsequence

   // ****************************************
   // Assertions
   // ****************************************
   wait_once_a:
      assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("request waited more than one cycle");
   pin_dir_a:
      assert property (c1_wr_s |-> ##2 o_aux_pin_oe == $past(i_avs_writedata[9:8], 2))
      else $error("pin enable does not follow direction");
   pin_drive_a:
      assert property (c1_wr_s |-> ##2 o_aux_pin_out == ($past(i_avs_writedata[9:8], 2) & $past(i_avs_writedata[1:0], 2)))
      else $error("pin drive does not follow out level");
   input_quiet_a:
      assert property ((o_aux_pin_out & ~o_aux_pin_oe) == 2'b00)
      else $error("pin driven while input");
   out_seen_a:
      assert property ($stable(o_aux_pin_oe) && $stable(o_aux_pin_out) |-> ((o_aux_level ^ o_aux_pin_out) & o_aux_pin_oe) == 2'b00)
      else $error("output pin level not static drive");
   tsb_level_a:
      assert property (c0_wr_s |=> o_test_source_b_level == $past(i_avs_writedata[2:0]))
      else $error("test source level not written");
   tsb_units_a:
      assert property (o_test_source_b_units == units_of($past(o_test_source_b_level)))
      else $error("test source units wrong");
   sec3_enable_a:
      assert property (c0_wr_s |=> o_section3_check_enable == $past(i_avs_writedata[15]))
      else $error("section 3 enable not written");
   aux_fixed_a:
      assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[9:2] == `RCSAP_IDX_AUX_CFG |-> o_avs_readdata[15])
      else $error("aux config bit 15 not one");
   fault_cause_a:
      assert property ($rose(o_section3_fault) |-> $past(o_section3_check_enable))
      else $error("fault raised while check disabled");
endmodule

bind rcsap_regs rcsap_regs_checker i_rcsap_regs_checker (
   .i_clk(i_clk), .i_srst(i_srst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_aux_pin(i_aux_pin),
   .o_aux_pin_out(o_aux_pin_out), .o_aux_pin_oe(o_aux_pin_oe), .o_aux_level(o_aux_level),
   .o_test_source_b_level(o_test_source_b_level), .o_test_source_b_units(o_test_source_b_units),
   .o_section3_check_enable(o_section3_check_enable), .o_section3_fault(o_section3_fault)
);

// ---- bench/rcsap_regs_bench.sv ----
// Self-checking bench for the aux pin and checksum register slice
`include "rcsap_consts.svh"

module rcsap_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic i_clk;
   logic i_srst;
   logic rd;
   logic wr;
   logic [9:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [1:0] pin;
   logic [31:0] rdata;
   logic wreq;
   logic [1:0] pout;
   logic [1:0] poe;
   logic [1:0] lvl;
   logic [2:0] tsb;
   logic [6:0] units;
   logic en;
   logic fault;
   int bad_count;
   int checks;
   int seed;
   logic [31:0] r;
   logic [31:0] last_rd;
   logic [15:0] exp_q [$];
   logic [7:0] idx_tab [5] = '{8'ha2, 8'ha3, 8'hbe, 8'hc0, 8'hc1};
   logic [15:0] mask_tab [5] = '{16'hff00, 16'hffff, 16'hffff, 16'h8007, 16'h7fff};
   logic [15:0] fix_tab [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
   logic [6:0] units_tab [8] = '{7'h01, 7'h02, 7'h04, 7'h09, 7'h12, 7'h24, 7'h7c, 7'h77};

   rcsap_regs i_rcsap_regs (
      .i_clk(i_clk), .i_srst(i_srst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .i_aux_pin(pin), .o_aux_pin_out(pout), .o_aux_pin_oe(poe), .o_aux_level(lvl),
      .o_test_source_b_level(tsb), .o_test_source_b_units(units), .o_section3_check_enable(en),
      .o_section3_fault(fault)
   );

   // ****************************************
   // Clock, tasks, read monitor
   // ****************************************
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task results();
      if (bad_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hold the request until waitrequest is seen low at a rising edge
   task bus(input logic is_rd, input logic [7:0] idx, input logic [15:0] d, input logic [1:0] b);
      @(posedge i_clk);
      addr <= {idx, 2'b00};
      rd <= is_rd;
      wr <= ~is_rd;
      wdata <= {16'h0000, d};
      be <= {2'b00, b};
      do
      begin
         @(posedge i_clk);
      end
      while (wreq !== 1'b0);
      last_rd = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task rd_chk(input logic [7:0] idx, input logic [15:0] exp);
      exp_q.push_back(exp);
      bus(1'b1, idx, 16'h0000, 2'b11);
   endtask

   task settle(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   task pwm(input int t, input int hi, input int lo, input logic exp);
      @(posedge i_clk);
      repeat (3)
      begin
         pin[0] <= 1'b1;
         repeat (hi * t) @(posedge i_clk);
         pin[0] <= 1'b0;
         repeat (lo * t) @(posedge i_clk);
      end
      pin[0] <= 1'b1;
      settle(8);
      check({31'h0000_0000, lvl[0]}, {31'h0000_0000, exp});
   endtask

   // Read data taken at the edge that sees waitrequest low
   always @(posedge i_clk)
      if (rd === 1'b1 && wreq === 1'b0 && exp_q.size() > 0)
         check(rdata, {16'h0000, exp_q.pop_front()});

   initial
   begin
      repeat (60000) @(posedge i_clk);
      bad_count++;
      results();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      seed = 32'hf602_55b2;
      i_srst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 10'h000;
      wdata = 32'h0000_0000;
      be = 4'h0;
      pin = 2'b00;
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      for (int i = 0; i < 5; i++) rd_chk(idx_tab[i], fix_tab[i]);
      bus(1'b0, 8'h10, 16'hffff, 2'b11);
      rd_chk(8'h10, 16'h0000);
      for (int k = 0; k < 2; k++)
         for (int i = 0; i < 5; i++)
         begin
            r = $random(seed);
            r[15:0] = k ? ~r[15:0] : r[15:0];
            bus(1'b0, idx_tab[i], r[15:0], 2'b11);
            rd_chk(idx_tab[i], (r[15:0] & mask_tab[i]) | fix_tab[i]);
         end
      bus(1'b0, 8'ha3, 16'hffff, 2'b11);
      bus(1'b0, 8'ha3, 16'h0000, 2'b01);
      rd_chk(8'ha3, 16'hff00);
      for (int c = 0; c < 8; c++)
      begin
         bus(1'b0, 8'hc0, 16'(c), 2'b11);
         settle(2);
         check({29'h0000_0000, tsb}, 32'(c));
         check({25'h000_0000, units}, {25'h000_0000, units_tab[c]});
      end
      bus(1'b0, 8'hc1, 16'h0f02, 2'b11);
      settle(2);
      check({26'h000_0000, poe, pout, lvl}, 32'h0000_003a);
      bus(1'b0, 8'hc1, 16'h0003, 2'b11);
      settle(2);
      check({28'h000_0000, poe, pout}, 32'h0000_0000);
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed);
         @(posedge i_clk);
         pin <= r[1:0];
         settle(4);
         check({30'h0000_0000, lvl}, {30'h0000_0000, r[1:0]});
      end
      // each time base, long pulses win
      for (int tb = 0; tb < 4; tb++)
      begin
         bus(1'b0, 8'hc1, 16'h0400 | 16'(tb << 4), 2'b11);
         pwm(16 << (2 * tb), 3, 1, 1'b1);
         pwm(16 << (2 * tb), 1, 3, 1'b0);
      end
      bus(1'b0, 8'hc1, 16'h0000, 2'b11);
      bus(1'b0, 8'hc0, 16'h0000, 2'b11);
      bus(1'b0, `RCSAP_IDX_STATUS, 16'h0001, 2'b01);
      settle(4);
      check({31'h0000_0000, fault}, 32'h0000_0000);
      bus(1'b0, 8'hc0, 16'h8000, 2'b11);
      settle(4);
      check({30'h0000_0000, en, fault}, 32'h0000_0003);
      bus(1'b0, `RCSAP_IDX_STATUS, 16'h0001, 2'b01);
      settle(3);
      check({31'h0000_0000, fault}, 32'h0000_0001);
      bus(1'b1, `RCSAP_IDX_SEC3_CALC, 16'h0000, 2'b11);
      bus(1'b0, `RCSAP_IDX_SEC3_REF, last_rd[15:0], 2'b11);
      bus(1'b0, `RCSAP_IDX_STATUS, 16'h0001, 2'b01);
      settle(3);
      check({30'h0000_0000, en, fault}, 32'h0000_0002);
      bus(1'b0, 8'hc0, 16'h0000, 2'b11);
      bus(1'b0, `RCSAP_IDX_STATUS, 16'h0001, 2'b01);
      settle(3);
      check({31'h0000_0000, fault}, 32'h0000_0000);
      @(posedge i_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      rd_chk(8'hc1, 16'h8000);
      rd_chk(8'ha3, 16'h0000);
      settle(2);
      results();
   end
endmodule
